// File: sft_sent_tx.sv
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
//
// Function
// R01 - every frame starts with a 56-tick sync and calibration pulse
// R02 - status nibble follows: bits 1:0 device status, 3:2 selected source
// R03 - three to six data nibbles follow, content set by layout select
// R04 - one CRC nibble follows the data nibbles
// R05 - each frame ends with a pause pulse sized to the frame rate; in modes 2 to 7 the code ends the pause after its 5-tick low phase
// R06 - seven transmission modes chosen by tx_mode_sel
// R07 - mode 1 sends frames back to back without requests
// R08 - continuous pause is at least 12 ticks, stretched to update rate
// R09 - modes 2 to 7 send a frame only after a trigger pulse
// R10 - triggered modes hold the line idle until the next trigger
// R11 - controller pulls the line low at least the minimum trigger width
// R12 - line stays high at least seven ticks after trigger rise
// R13 - modes 6 and 7 sample data at the trigger falling edge
// R14 - mode 2 samples data at the end of the status nibble
// R15 - minimum trigger width from config, or fixed pulse width modes 3/4
// R16 - 5-bit code picks the tick period
// R17 - tick codes below 0.5 us are unsupported
// R18 - CRC uses x^4+x^3+x^2+1 with seed 0101
// R19 - optional inclusion of the status nibble in the CRC
// R20 - eight layouts of 3 to 6 nibbles from mag, diag, count, temp
// R21 - frame counter advances per frame and wraps to zero
// R22 - nibble of value v lasts 12+v ticks, falling edge to falling edge
// R23 - each period drives low for fixed ticks then releases high
module sft_sent_tx #(
   parameter int UPDATE_TICKS = sft_pkg::UPDATE_TICKS
) (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic [7:0]  addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic [31:0]      rdata_out,
   input  wire logic [15:0] mag_in,
   input  wire logic [7:0]  diag_in,
   input  wire logic [11:0] temp_in,
   input  wire logic [1:0]  dev_status_in,
   input  wire logic [1:0]  serial_msg_in,
   input  wire logic        line_in,
   output logic             line_out,
   output logic             line_oe_out
);
   if (UPDATE_TICKS < sft_pkg::MAX_FRAME || UPDATE_TICKS > 1023) begin
      $error("UPDATE_TICKS out of range");
   end
   localparam logic [9:0] UPD = 10'(UPDATE_TICKS);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   sft_pkg::sft_state_e state;
   sft_pkg::sft_state_e next_state;
   logic [31:0] cfg;
   logic [31:0] next_cfg;
   logic [31:0] next_rdata;
   logic [9:0]  tcnt;
   logic [9:0]  next_tcnt;
   logic [9:0]  ftick;
   logic [9:0]  next_ftick;
   logic [2:0]  didx;
   logic [2:0]  next_didx;
   logic [3:0]  nib;
   logic [3:0]  next_nib;
   logic [15:0] s_mag;
   logic [15:0] next_s_mag;
   logic [7:0]  s_diag;
   logic [7:0]  next_s_diag;
   logic [11:0] s_temp;
   logic [11:0] next_s_temp;
   logic [11:0] fcnt;
   logic [11:0] next_fcnt;
   logic [7:0]  lo_cnt;
   logic [7:0]  next_lo_cnt;
   logic        line_d;
   logic        next_oe;
   logic        tick;
   logic        tick_bad;
   logic        crc_clr;
   logic        crc_step;
   logic [3:0]  crc_val;
   logic [2:0]  mode;
   logic        trig_mode;
   logic        sync_trig;
   logic [7:0]  min_w;
   logic        per_end;
   logic        capture;

   sft_tick_gen u_tick (
      .clk_in  (clk_in),
      .rst_in  (rst_in),
      .code_in (cfg[sft_pkg::CFG_TICK +: 5]),
      .tick_out(tick),
      .bad_out (tick_bad)
   );

   sft_crc4 u_crc (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .clr_in (crc_clr),
      .step_in(crc_step),
      .nib_in (next_nib),
      .crc_out(crc_val)
   );

   // ----------------------------------------------------------------
   // payload decode
   // ----------------------------------------------------------------
   function automatic logic [2:0] nib_count(input logic [2:0] lay);
      nib_count = (lay == 3'd0) ? 3'd3 : (lay == 3'd4) ? 3'd4 : 3'd6;  // R20
   endfunction

   function automatic logic [3:0] data_nib(input logic [2:0] lay, input logic [2:0] i,
                                           input logic [15:0] m, input logic [7:0] d,
                                           input logic [11:0] t, input logic [11:0] c);
      logic [23:0] w;
      w = {m[15:4], c};
      case (lay)                                                      // R20
         3'd1:    w = {m[15:4], d, c[3:0]};
         3'd2:    w = {m[15:4], c};
         3'd3:    w = {m[15:4], t};
         3'd5:    w = {m, d};
         3'd6:    w = {m, c[7:0]};
         3'd7:    w = {m, t[11:4]};
         default: w = {m, 8'h00};
      endcase
      data_nib = w[5'(20 - 4 * int'(i)) +: 4];
   endfunction

   // ----------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------
   always_comb begin
      mode      = cfg[sft_pkg::CFG_MODE +: 3];                        // R06
      sync_trig = (mode == 3'd6) || (mode == 3'd7);
      trig_mode = sync_trig || (mode >= sft_pkg::MODE_ASYNC && mode <= 3'd5); // R09
      if (mode == sft_pkg::MODE_LONG) begin
         min_w = sft_pkg::LONG_MIN_W;                                 // R15
      end else if (mode == sft_pkg::MODE_SHORT) begin
         min_w = sft_pkg::SHORT_MIN_W;                                // R15
      end else begin
         min_w = cfg[sft_pkg::CFG_TRIGW +: 8];                        // R15
      end
      per_end = tick && (tcnt == 10'(sft_pkg::NIB_BASE + 10'(nib) - 10'd1)); // R22
   end

   // ----------------------------------------------------------------
   // frame sequencer
   // ----------------------------------------------------------------
   always_comb begin
      next_state  = state;
      next_tcnt   = tick ? 10'(tcnt + 10'd1) : tcnt;
      next_ftick  = (tick && ftick != 10'h3FF) ? 10'(ftick + 10'd1) : ftick;
      next_didx   = didx;
      next_nib    = nib;
      next_fcnt   = fcnt;
      // our own low phases must never count towards a trigger width
      next_lo_cnt = line_oe_out ? 8'h00
                  : (tick && !line_in && lo_cnt != 8'hFF) ? 8'(lo_cnt + 8'd1) : lo_cnt;
      crc_clr     = 1'b0;
      crc_step    = 1'b0;
      capture     = 1'b0;
      // a falling edge made by the controller restarts the width count
      if (line_d && !line_in && !line_oe_out) begin
         next_lo_cnt = 8'h00;
         if (sync_trig && state == sft_pkg::SFT_IDLE) begin
            capture = 1'b1;                                           // R13
         end
      end
      case (state)
         sft_pkg::SFT_IDLE: begin
            next_tcnt = 10'h000;
            if (!cfg[sft_pkg::CFG_EN]) begin
               next_state = sft_pkg::SFT_IDLE;
            end else if (mode == sft_pkg::MODE_CONT && tick) begin
               next_state = sft_pkg::SFT_SYNC;                        // R07
               next_ftick = 10'h000;
               crc_clr    = 1'b1;
               capture    = 1'b1;
            end else if (trig_mode && !line_d && line_in && lo_cnt >= min_w) begin
               next_state = sft_pkg::SFT_HOLD;                        // R09 R11
            end
         end
         sft_pkg::SFT_HOLD: begin
            // the first tick may come at once: one extra keeps seven full ticks
            if (tick && tcnt == sft_pkg::HOLD_TICKS) begin
               next_state = sft_pkg::SFT_SYNC;                        // R12
               next_tcnt  = 10'h000;
               next_ftick = 10'h000;
               crc_clr    = 1'b1;
            end
         end
         sft_pkg::SFT_SYNC: begin
            if (tick && tcnt == 10'(sft_pkg::SYNC_TICKS - 10'd1)) begin
               next_state = sft_pkg::SFT_STATUS;                      // R01
               next_tcnt  = 10'h000;
               case (cfg[sft_pkg::CFG_SRC +: 2])                      // R02
                  2'd1:    next_nib = {2'b00, dev_status_in};
                  2'd2:    next_nib = {cfg[sft_pkg::CFG_DIE +: 2], dev_status_in};
                  default: next_nib = {serial_msg_in, dev_status_in};
               endcase
               crc_step = cfg[sft_pkg::CFG_CRCST];                    // R19
            end
         end
         sft_pkg::SFT_STATUS: begin
            if (per_end) begin
               capture    = (mode == sft_pkg::MODE_ASYNC);            // R14
               next_state = sft_pkg::SFT_DATA;                        // R03
               next_tcnt  = 10'h000;
               next_didx  = 3'd0;
               next_nib   = data_nib(cfg[sft_pkg::CFG_LAYOUT +: 3], 3'd0,
                                     capture ? mag_in : s_mag, s_diag, s_temp, fcnt);
               crc_step   = 1'b1;
            end
         end
         sft_pkg::SFT_DATA: begin
            if (per_end) begin
               next_tcnt = 10'h000;
               if (didx == 3'(nib_count(cfg[sft_pkg::CFG_LAYOUT +: 3]) - 3'd1)) begin
                  next_state = sft_pkg::SFT_CRC;                      // R04
                  next_nib   = crc_val;
                  next_fcnt  = 12'(fcnt + 12'd1);                     // R21
               end else begin
                  next_didx = 3'(didx + 3'd1);
                  next_nib  = data_nib(cfg[sft_pkg::CFG_LAYOUT +: 3], next_didx,
                                       s_mag, s_diag, s_temp, fcnt);
                  crc_step  = 1'b1;
               end
            end
         end
         sft_pkg::SFT_CRC: begin
            if (per_end) begin
               next_state = sft_pkg::SFT_PAUSE;                       // R05
               next_tcnt  = 10'h000;
            end
         end
         sft_pkg::SFT_PAUSE: begin
            if (!cfg[sft_pkg::CFG_EN] || (trig_mode && tick && tcnt == 10'(sft_pkg::LOW_TICKS
                - 10'd1))) begin
               next_state = sft_pkg::SFT_IDLE;                        // R10
            end else if (mode == sft_pkg::MODE_CONT && tick
                         && tcnt >= 10'(sft_pkg::PAUSE_MIN - 10'd1) && ftick >= UPD - 10'd1) begin
               next_state = sft_pkg::SFT_SYNC;                        // R08
               next_tcnt  = 10'h000;
               next_ftick = 10'h000;
               crc_clr    = 1'b1;
               capture    = 1'b1;
            end
         end
         default: begin
            next_state = sft_pkg::SFT_IDLE;
         end
      endcase
      next_s_mag  = capture ? mag_in : s_mag;
      next_s_diag = capture ? diag_in : s_diag;
      next_s_temp = capture ? temp_in : s_temp;
      // low phase opens every period, then the line is released
      next_oe = (next_state != sft_pkg::SFT_IDLE) && (next_state != sft_pkg::SFT_HOLD)
                && (next_tcnt < sft_pkg::LOW_TICKS);                  // R23
   end

   // ----------------------------------------------------------------
   // register port; reads answer one cycle later, unmapped reads zero
   // ----------------------------------------------------------------
   always_comb begin
      next_cfg   = (wr_in && addr_in == sft_pkg::ADDR_CFG) ? wdata_in : cfg;
      next_rdata = 32'h0000_0000;
      if (rd_in && addr_in == sft_pkg::ADDR_CFG) begin
         next_rdata = cfg;
      end else if (rd_in && addr_in == sft_pkg::ADDR_STAT) begin
         next_rdata = {4'h0, fcnt, 12'h000, tick_bad, state};
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state       <= sft_pkg::SFT_IDLE;
         cfg         <= sft_pkg::CFG_RESET;
         rdata_out   <= 32'h0000_0000;
         tcnt        <= 10'h000;
         ftick       <= 10'h000;
         didx        <= 3'd0;
         nib         <= 4'h0;
         s_mag       <= 16'h0000;
         s_diag      <= 8'h00;
         s_temp      <= 12'h000;
         fcnt        <= 12'h000;
         lo_cnt      <= 8'h00;
         line_d      <= 1'b1;
         line_oe_out <= 1'b0;
         line_out    <= 1'b0;
      end else begin
         state       <= next_state;
         cfg         <= next_cfg;
         rdata_out   <= next_rdata;
         tcnt        <= next_tcnt;
         ftick       <= next_ftick;
         didx        <= next_didx;
         nib         <= next_nib;
         s_mag       <= next_s_mag;
         s_diag      <= next_s_diag;
         s_temp      <= next_s_temp;
         fcnt        <= next_fcnt;
         lo_cnt      <= next_lo_cnt;
         line_d      <= line_in;
         line_oe_out <= next_oe;
         line_out    <= 1'b0;     // open drain: only ever pulls low
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sync_length_a: assert property (@(posedge clk_in) disable iff (rst_in) // R01
      (state == sft_pkg::SFT_SYNC && tick && tcnt == 10'd55)
      |=> state == sft_pkg::SFT_STATUS) else $error("sync pulse not 56 ticks");
   nibble_hold_a: assert property (@(posedge clk_in) disable iff (rst_in) // R22
      (state == sft_pkg::SFT_DATA && tick && tcnt != 10'(10'd11 + 10'(nib)))
      |=> state == sft_pkg::SFT_DATA && tcnt == $past(tcnt) + 10'd1)
      else $error("data nibble cut short");
   hold_high_a: assert property (@(posedge clk_in) disable iff (rst_in) // R12
      (state == sft_pkg::SFT_IDLE && next_state == sft_pkg::SFT_HOLD)
      |=> !line_oe_out [*7]) else $error("line driven within hold gap");
   pause_min_a: assert property (@(posedge clk_in) disable iff (rst_in) // R08
      (state == sft_pkg::SFT_PAUSE && mode == sft_pkg::MODE_CONT && cfg[sft_pkg::CFG_EN]
       && tcnt < 10'd11) |=> state == sft_pkg::SFT_PAUSE) else $error("pause too short");
   trig_wait_a: assert property (@(posedge clk_in) disable iff (rst_in) // R10
      (state == sft_pkg::SFT_IDLE && trig_mode && !(!line_d && line_in))
      |=> state == sft_pkg::SFT_IDLE) else $error("frame sent without trigger");
   cont_start_a: assert property (@(posedge clk_in) disable iff (rst_in) // R07
      (state == sft_pkg::SFT_IDLE && mode == sft_pkg::MODE_CONT && cfg[sft_pkg::CFG_EN]
       && tick)
      |=> state == sft_pkg::SFT_SYNC ##1 line_oe_out) else $error("continuous frame missing");
   frame_count_a: assert property (@(posedge clk_in) disable iff (rst_in) // R21
      (state == sft_pkg::SFT_DATA && next_state == sft_pkg::SFT_CRC)
      |=> fcnt == 12'($past(fcnt) + 12'd1)) else $error("frame counter not advanced");
   crc_nibble_a: assert property (@(posedge clk_in) disable iff (rst_in) // R04
      (state == sft_pkg::SFT_DATA && next_state == sft_pkg::SFT_CRC)
      |=> nib == $past(crc_val)) else $error("crc nibble mismatch");
endmodule
`default_nettype wire

// File: sft_pkg.sv
package sft_pkg;
   // ----------------------------------------------------------------
   // register map and configuration fields
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CFG    = 8'h00;
   localparam logic [7:0] ADDR_STAT   = 8'h04;
   localparam int         CFG_MODE    = 0;   // [2:0] tx_mode_sel
   localparam int         CFG_TICK    = 3;   // [7:3] tick code
   localparam int         CFG_LAYOUT  = 8;   // [10:8] payload_layout_sel
   localparam int         CFG_SRC     = 11;  // [12:11] status_nibble_src_sel
   localparam int         CFG_CRCST   = 13;  // crc_status_include
   localparam int         CFG_TRIGW   = 14;  // [21:14] trig_min_width_sel, ticks
   localparam int         CFG_DIE     = 22;  // [23:22] die address
   localparam int         CFG_EN      = 24;  // normal operation
   localparam logic [31:0] CFG_RESET  = 32'h0002_0001;
   localparam int         STAT_BAD    = 3;
   localparam int         STAT_CNT    = 16;

   // ----------------------------------------------------------------
   // modes and frame timing in ticks
   // ----------------------------------------------------------------
   localparam logic [2:0] MODE_CONT   = 3'h1;
   localparam logic [2:0] MODE_ASYNC  = 3'h2;
   localparam logic [2:0] MODE_LONG   = 3'h3;
   localparam logic [2:0] MODE_SHORT  = 3'h4;
   localparam logic [7:0] LONG_MIN_W  = 8'h09;
   localparam logic [7:0] SHORT_MIN_W = 8'h0F;
   localparam logic [9:0] SYNC_TICKS  = 10'h038;
   localparam logic [9:0] NIB_BASE    = 10'h00C;
   localparam logic [9:0] PAUSE_MIN   = 10'h00C;
   localparam logic [9:0] HOLD_TICKS  = 10'h007;
   localparam logic [9:0] LOW_TICKS   = 10'h005;
   localparam int         MAX_FRAME   = 284;
   localparam int         UPDATE_TICKS = 300;
   localparam logic [3:0] CRC_SEED    = 4'h5;
   localparam logic [3:0] CRC_POLY    = 4'hD;  // x^4+x^3+x^2+1, top term implied

   // ----------------------------------------------------------------
   // tick periods in ns and clock rate
   // ----------------------------------------------------------------
   localparam int         CLK_MHZ     = 125;
   localparam logic [13:0] CLK_NS     = 14'(1000 / CLK_MHZ);
   localparam logic [13:0] T_DEFAULT  = 14'h03E8;  // 1 us
   localparam logic [13:0] T_FINE0    = 14'h01F4;  // 0.5 us
   localparam logic [13:0] T_FINE_ST  = 14'h007D;  // 0.125 us
   localparam logic [13:0] T_MID0     = 14'h0DAC;  // 3.5 us
   localparam logic [13:0] T_MID_ST   = 14'h01F4;  // 0.5 us
   localparam logic [13:0] T_CODE30   = 14'h1B58;  // 7 us
   localparam logic [13:0] T_CODE31   = 14'h2710;  // 10 us

   typedef enum logic [2:0] {
      SFT_IDLE   = 3'b000,
      SFT_HOLD   = 3'b001,
      SFT_SYNC   = 3'b011,
      SFT_STATUS = 3'b010,
      SFT_DATA   = 3'b110,
      SFT_CRC    = 3'b111,
      SFT_PAUSE  = 3'b101
   } sft_state_e;
endpackage

// File: sft_tick_gen.sv
`timescale 1ns/10ps
`default_nettype none
module sft_tick_gen (
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic [4:0] code_in,
   output logic            tick_out,
   output logic            bad_out
);
   logic [13:0] acc;
   logic [13:0] next_acc;
   logic [13:0] period;
   logic        next_tick;
   logic        next_bad;

   // ----------------------------------------------------------------
   // code to period; unsupported sub-0.5us codes fall back to 1 us
   // ----------------------------------------------------------------
   function automatic logic [13:0] tick_ns(input logic [4:0] c);
      if (c >= 5'd3 && c <= 5'd23) begin
         tick_ns = 14'(sft_pkg::T_FINE0 + 14'(c - 5'd3) * sft_pkg::T_FINE_ST);
      end else if (c >= 5'd24 && c <= 5'd29) begin
         tick_ns = 14'(sft_pkg::T_MID0 + 14'(c - 5'd24) * sft_pkg::T_MID_ST);
      end else if (c == 5'd30) begin
         tick_ns = sft_pkg::T_CODE30;
      end else if (c == 5'd31) begin
         tick_ns = sft_pkg::T_CODE31;
      end else begin
         tick_ns = sft_pkg::T_DEFAULT;
      end
   endfunction

   // fractional accumulator keeps the long-run tick rate exact
   always_comb begin
      period    = tick_ns(code_in);                                   // R16
      next_bad  = (code_in == 5'd1) || (code_in == 5'd2);             // R17
      next_acc  = 14'(acc + sft_pkg::CLK_NS);
      next_tick = 1'b0;
      if (next_acc >= period) begin
         next_acc  = 14'(next_acc - period);
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         acc      <= 14'h0000;
         tick_out <= 1'b0;
         bad_out  <= 1'b0;
      end else begin
         acc      <= next_acc;
         tick_out <= next_tick;
         bad_out  <= next_bad;
      end
   end

   tick_bad_a: assert property (@(posedge clk_in) disable iff (rst_in) // R17
      (code_in == 5'd1) |=> bad_out) else $error("invalid tick code not flagged");
endmodule
`default_nettype wire

// File: sft_crc4.sv
`timescale 1ns/10ps
`default_nettype none
module sft_crc4 (
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       clr_in,
   input  wire logic       step_in,
   input  wire logic [3:0] nib_in,
   output logic [3:0]      crc_out
);
   logic [3:0] crc;
   logic [3:0] next_crc;
   logic [3:0] next_out;

   // multiply by x^4 modulo the generator
   function automatic logic [3:0] mul_x4(input logic [3:0] c);
      logic [3:0] r;
      r = c;
      for (int i = 0; i < 4; i++) begin
         r = r[3] ? ({r[2:0], 1'b0} ^ sft_pkg::CRC_POLY) : {r[2:0], 1'b0};
      end
      mul_x4 = r;
   endfunction

   // table-free nibble update, final zero nibble appended on output
   always_comb begin
      next_crc = crc;
      if (clr_in) begin
         next_crc = sft_pkg::CRC_SEED;                                // R18
      end else if (step_in) begin
         next_crc = mul_x4(crc) ^ nib_in;                             // R18
      end
      next_out = mul_x4(next_crc);
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         crc     <= sft_pkg::CRC_SEED;
         crc_out <= 4'h0;
      end else begin
         crc     <= next_crc;
         crc_out <= next_out;
      end
   end
endmodule
`default_nettype wire

// File: sft_ecu_model.sv
`timescale 1ns/10ps
`default_nettype none
module sft_ecu_model (
   input  wire logic clk_in,
   input  wire logic oe_in,
   output logic      line_out
);
   // ------------------------
   // receiver side of the wire
   // ------------------------
   logic pull = 1'b0;
   logic prev = 1'b1;
   int   cyc  = 0;
   int   rel  = 0;
   int   falls[$];
   // pull-up wire: low while either side pulls, so never left floating
   assign line_out = !(oe_in | pull);
   // stamp each falling edge in clocks
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      prev <= line_out;
      if (prev && !line_out) falls.push_back(cyc);
   end
   // request pulse: low for n ticks, then release
   task automatic trig(input int n);
      pull <= 1'b1;
      repeat (n * 125 / 2) @(posedge clk_in);
      pull <= 1'b0;
      rel = cyc;
   endtask
endmodule
`default_nettype wire

// File: sft_sent_tx_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module sft_sent_tx_tb_top;
   logic        clk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic [7:0]  addr_in;
   logic [31:0] wdata_in;
   logic        wr_in;
   logic        rd_in;
   logic [31:0] rdata_out;
   logic [15:0] mag_in;
   logic [1:0]  dev_status_in;
   logic [7:0]  diag_in;
   logic [11:0] temp_in;
   logic [1:0]  serial_msg_in;
   logic        line_lvl;
   logic        line_w;
   logic        line_oe_out;
   int          error_cnt = 0;
   int          tests_run = 0;
   // 8 ns clock
   always #4 clk_in = ~clk_in;
   sft_sent_tx #(.UPDATE_TICKS(284)) u_sft_sent_tx (.clk_in, .rst_in, .addr_in, .wdata_in,
      .wr_in, .rd_in, .rdata_out, .mag_in, .diag_in, .temp_in,
      .dev_status_in, .serial_msg_in, .line_in(line_w), .line_out(line_lvl),
      .line_oe_out);
   sft_ecu_model u_sft_ecu_model (.clk_in, .oe_in(line_oe_out), .line_out(line_w));
   // ------------------------
   // access and check tasks
   // ------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %0t: read %h expected %h", $time, g, e);
      end
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 cmp_reg(rdata_out, e);
      @(posedge clk_in);
   endtask
   task automatic cmp_tk(input int g, input int e);
      tests_run++;
      if (g != e) begin
         error_cnt++;
         $display("Error %0t: got %0d expected %0d", $time, g, e);
      end
   endtask
   // a tick is 62.5 clocks at code 3, so round
   function automatic int tk(input int c);
      return (c * 2 + 62) / 125;
   endfunction
   function automatic logic [31:0] cfg(input logic [2:0] m, input logic c);
      return 32'h1 << 24 | 32'h8 << 14 | 32'(c) << 13 | 32'h1 << 11 | 32'h3 << 3 | 32'(m);
   endfunction
   task automatic wait_f(input int n);
      int k;
      k = 0;
      while (u_sft_ecu_model.falls.size() < n && k < 30000) begin
         @(posedge clk_in);
         k++;
      end
      if (k == 30000) error_cnt++;
   endtask
   // frame from edge b: sync, status, three data, crc, and the pause only when cont is set
   task automatic chk_frame(input int b, input logic [15:0] m, input logic inc,
                            input logic cont);
      logic [3:0] n[5];
      logic [3:0] c;
      int         s;
      int         i;
      int         j;
      n = '{{2'b00, dev_status_in}, m[15:12], m[11:8], m[7:4], 4'h0};
      // nibble-wise update, then one zero nibble pushed through
      c = 4'h5;
      for (i = inc ? 0 : 1; i < 5; i++) begin
         for (j = 0; j < 4; j++) c = {c[2:0], 1'b0} ^ (c[3] ? 4'hD : 4'h0);
         if (i < 4) c = c ^ n[i];
      end
      n[4] = c;
      s = 56;
      cmp_tk(tk(u_sft_ecu_model.falls[b+1] - u_sft_ecu_model.falls[b]), 56);
      for (i = 0; i < 5; i++) begin
         cmp_tk(tk(u_sft_ecu_model.falls[b+i+2] - u_sft_ecu_model.falls[b+i+1]), 12 + n[i]);
         s += 12 + n[i];
      end
      if (cont) cmp_tk(tk(u_sft_ecu_model.falls[b+7] - u_sft_ecu_model.falls[b+6]), 284 - s);
   endtask
   // trigger with data moved during the pulse and after sync start
   task automatic trig_frame(input logic [2:0] md, input logic inc, input logic [15:0] e);
      wr(8'h00, cfg(md, inc));
      u_sft_ecu_model.falls.delete();
      mag_in <= 16'h1234;
      fork
         u_sft_ecu_model.trig(10);
         begin
            repeat (100) @(posedge clk_in);
            mag_in <= 16'h5678;
         end
      join
      wait_f(2);
      mag_in <= 16'h9ABC;
      wait_f(8);
      cmp_tk(tk(u_sft_ecu_model.falls[1] - u_sft_ecu_model.rel) >= 7, 1);
      chk_frame(1, e, inc, 1'b0);
      repeat (2500) @(posedge clk_in);
      cmp_tk(u_sft_ecu_model.falls.size(), 8);
      cmp_reg({31'h0, line_lvl}, 32'h0);
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // watchdog well beyond the expected run
   initial begin
      repeat (92000) @(posedge clk_in);
      error_cnt++;
      end_of_test();
   end
   initial begin
      addr_in = 8'h00;
      wdata_in = 32'h0;
      wr_in = 1'b0;
      rd_in = 1'b0;
      mag_in = 16'hA5C3;
      dev_status_in = 2'b10;
      diag_in = 8'h3C;
      temp_in = 12'h123;
      serial_msg_in = 2'h1;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      rd(8'h00, 32'h0002_0001);
      rd(8'h08, 32'h0);
      wr(8'h00, cfg(3'h1, 1'b0));
      u_sft_ecu_model.falls.delete();
      wait_f(8);
      chk_frame(0, 16'hA5C3, 1'b0, 1'b1);
      wr(8'h00, cfg(3'h2, 1'b0));
      repeat (14000) @(posedge clk_in);
      u_sft_ecu_model.falls.delete();
      u_sft_ecu_model.trig(3);
      repeat (6000) @(posedge clk_in);
      cmp_tk(u_sft_ecu_model.falls.size(), 1);
      trig_frame(3'h6, 1'b0, 16'h1234);
      trig_frame(3'h7, 1'b1, 16'h1234);
      trig_frame(3'h2, 1'b1, 16'h9ABC);
      rd(8'h04, 32'h0005_0000);
      wr(8'h00, 32'h0100_000A);
      rd(8'h04, 32'h0005_0008);
      end_of_test();
   end
endmodule
`default_nettype wire
